/* pkg/adc_port_cfg.svh */
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// write word layout: target register in the top two bits
`define TARGET_HI        15
`define TARGET_LO        14
`define TARGET_TEST      2'h1
`define TARGET_CONTROL   2'h2
// control register fields
`define RDSEL_HI         13
`define RDSEL_LO         12
`define CALTYPE_HI       5
`define CALTYPE_LO       4
`define CAL_START_BIT    3
`define CONVERT_BIT      2
// read selection codes
`define RDSEL_RESULT     2'h0
`define RDSEL_STATUS     2'h1
`define RDSEL_TEST       2'h2
`define RDSEL_CONTROL    2'h3
// reset and recovery values
`define CONTROL_RESET    16'h0000
`define TEST_DEFAULT     16'h0000
`define TEST_RECOVERY    16'h4002
`define WORD_ZERO        16'h0000
`define BYTE_ZERO        8'h00
`define NIBBLE_ZERO      4'h0
`define LINES_ZERO       12'h000

`endif

/* pkg/adc_port_pkg.sv */
package adc_port_pkg;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE        = 7'h01,
    ST_CONV        = 7'h02,
    ST_CAL_DAC     = 7'h04,
    ST_CAL_GAIN    = 7'h08,
    ST_HOLD_OFFSET = 7'h10,
    ST_CAL_OFFSET  = 7'h20,
    ST_CAL_SINGLE  = 7'h40
  } seq_state_t;

  // calibration type field of the control register
  typedef enum logic [1:0] {
    CAL_FULL     = 2'h0,
    CAL_GAIN_OFF = 2'h1,
    CAL_OFFSET   = 2'h2,
    CAL_GAIN     = 2'h3
  } cal_type_t;

  // phase handed to the converter core
  typedef enum logic [1:0] {
    PHASE_DAC    = 2'h0,
    PHASE_GAIN   = 2'h1,
    PHASE_OFFSET = 2'h2,
    PHASE_NONE   = 2'h3
  } cal_phase_t;

endpackage

/* pkg/cal_link_if.sv */
`timescale 1ns/1ps
interface cal_link_if;
  import adc_port_pkg::*;

  logic       ctl_write;     // one-cycle pulse: control word committed
  logic       cal_start;     // start bit of that word
  cal_type_t  cal_type;
  logic       convert;       // convert bit of that word
  logic       trigger_fall;  // one-cycle pulse: convert trigger edge
  logic       core_done;     // one-cycle pulse from converter core
  logic       result_load;   // one-cycle pulse: latch conversion result
  logic       busy_state;    // level: sequencer is busy
  seq_state_t state;

  modport port (output ctl_write, output cal_start, output cal_type, output convert,
                output trigger_fall, output core_done,
                input result_load, input busy_state, input state);
  modport seq  (input ctl_write, input cal_start, input cal_type, input convert,
                input trigger_fall, input core_done,
                output result_load, output busy_state, output state);
endinterface

/* logic/cal_sequencer.sv */
`timescale 1ns/1ps
`include "adc_port_cfg.svh"
module cal_sequencer
  import adc_port_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // link to the parallel port
  cal_link_if.seq         link,
  // converter core controls
  output logic            conv_start_out,
  output logic            cal_start_out,
  output cal_phase_t      cal_phase_out
);

  seq_state_t state;
  logic       offset_go;

  // a convert bit write or a trigger edge both release the offset phase
  assign offset_go = (link.ctl_write && link.convert) || link.trigger_fall;

  // state walk; triggers only matter in idle or hold, so busy gates them
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state          <= ST_IDLE;
      conv_start_out <= 1'b0;
      cal_start_out  <= 1'b0;
      cal_phase_out  <= PHASE_NONE;
      link.result_load <= 1'b0;
    end
    else
    begin
      conv_start_out   <= 1'b0;
      cal_start_out    <= 1'b0;
      link.result_load <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          if (link.ctl_write && link.cal_start)
          begin
            cal_start_out <= 1'b1;
            unique case (link.cal_type)
              CAL_FULL:
              begin
                state         <= ST_CAL_DAC;
                cal_phase_out <= PHASE_DAC;
              end
              CAL_GAIN_OFF:
              begin
                state         <= ST_CAL_GAIN;
                cal_phase_out <= PHASE_GAIN;
              end
              CAL_OFFSET:
              begin
                state         <= ST_CAL_SINGLE;
                cal_phase_out <= PHASE_OFFSET;
              end
              CAL_GAIN:
              begin
                state         <= ST_CAL_SINGLE;
                cal_phase_out <= PHASE_GAIN;
              end
            endcase
          end
          else if (offset_go)
          begin
            state          <= ST_CONV;
            conv_start_out <= 1'b1;
          end
        end
        ST_CONV:
          if (link.core_done)
          begin
            state            <= ST_IDLE;
            link.result_load <= 1'b1;
          end
        ST_CAL_DAC:
          if (link.core_done)
          begin
            state         <= ST_CAL_GAIN;
            cal_start_out <= 1'b1;
            cal_phase_out <= PHASE_GAIN;
          end
        ST_CAL_GAIN:
          if (link.core_done)
            state <= ST_HOLD_OFFSET;
        ST_HOLD_OFFSET:
          if (offset_go)
          begin
            state         <= ST_CAL_OFFSET;
            cal_start_out <= 1'b1;
            cal_phase_out <= PHASE_OFFSET;
          end
        ST_CAL_OFFSET,
        ST_CAL_SINGLE:
          if (link.core_done)
          begin
            state         <= ST_IDLE;
            cal_phase_out <= PHASE_NONE;
          end
      endcase
    end
  end

  // busy everywhere except idle and the pause before the offset phase
  assign link.busy_state = !(state == ST_IDLE || state == ST_HOLD_OFFSET);
  assign link.state      = state;

endmodule

/* logic/adc_parallel_port.sv */
`timescale 1ns/1ps
`include "adc_port_cfg.svh"
module adc_parallel_port
  import adc_port_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // host strobes and select
  input  wire logic        chip_select_n_in,
  input  wire logic        read_strobe_n_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic        byte_select_in,
  input  wire logic        convert_trigger_n_in,
  // host data lines, split into in, out and enable
  input  wire logic [11:0] data_in,
  output logic      [11:0] data_out,
  output logic             data_oe_out,
  // conversion status
  output logic             busy_out,
  // converter core
  input  wire logic        core_done_in,
  input  wire logic [11:0] conv_result_in,
  output logic             conv_start_out,
  output logic             cal_start_out,
  output cal_phase_t       cal_phase_out
);

  // picks the part of a word that one access shows on the twelve lines
  function automatic logic [11:0] read_part(input logic [15:0] word, input logic hi);
    logic [11:0] part;
    part = hi ? {`NIBBLE_ZERO, word[15:8]} : word[11:0];
    return part;
  endfunction

  // tells whether a committed word is aimed at the given register
  function automatic logic aims_at(input logic [15:0] word, input logic [1:0] target);
    logic hit;
    hit = (word[`TARGET_HI:`TARGET_LO] == target);
    return hit;
  endfunction

  cal_link_if link ();

  // strobe windows
  logic        wr_window;
  logic        rd_window;
  logic        wr_window_q;
  logic        wr_end;
  // write assembly
  logic [7:0]  wr_byte_q;
  logic        wr_hi_q;
  logic [7:0]  low_hold;
  logic        low_valid;
  logic        commit;
  logic [15:0] commit_word;
  logic        ctl_hit;
  logic        test_hit;
  // registers
  logic [15:0] control_reg;
  logic [15:0] test_reg;
  logic [15:0] result_reg;
  logic [15:0] status_word;
  logic [15:0] read_word;
  // trigger edge and busy pipeline
  logic        trigger_q;
  logic        busy_q1;
  logic        busy_q2;

  // strobes are gated with chip select, so either may frame the access
  assign wr_window = !chip_select_n_in && !write_strobe_n_in;
  assign rd_window = !chip_select_n_in && !read_strobe_n_in;
  assign wr_end    = wr_window_q && !wr_window;

  // target decode of the word committed this cycle
  assign ctl_hit  = commit && aims_at(commit_word, `TARGET_CONTROL);
  assign test_hit = commit && aims_at(commit_word, `TARGET_TEST);

  // sample data and select every cycle of the write window; the last sample
  // before the strobe rises is what counts, like a rising-edge latch
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_window_q <= 1'b0;
      wr_byte_q   <= `BYTE_ZERO;
      wr_hi_q     <= 1'b0;
    end
    else
    begin
      wr_window_q <= wr_window;
      if (wr_window)
      begin
        wr_byte_q <= data_in[7:0];
        wr_hi_q   <= byte_select_in;
      end
    end
  end

  // byte pairing: low byte waits, high byte completes the word
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      low_hold    <= `BYTE_ZERO;
      low_valid   <= 1'b0;
      commit      <= 1'b0;
      commit_word <= `WORD_ZERO;
    end
    else
    begin
      commit <= 1'b0;
      if (wr_end)
      begin
        if (!wr_hi_q)
        begin
          low_hold  <= wr_byte_q;
          low_valid <= 1'b1;
        end
        else
        begin
          commit      <= 1'b1;
          commit_word <= {wr_byte_q, low_hold};
          low_valid   <= 1'b0;
        end
      end
    end
  end

  // control register: written at any time, even mid-conversion
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      control_reg <= `CONTROL_RESET;
    else if (ctl_hit)
      control_reg <= commit_word;
  end

  // test register: stray writes land here; the recovery word puts it back
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      test_reg <= `TEST_DEFAULT;
    else if (test_hit)
    begin
      if (commit_word == `TEST_RECOVERY)
        test_reg <= `TEST_DEFAULT;
      else
        test_reg <= commit_word;
    end
  end

  // control command pulse toward the sequencer, one cycle after commit
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      link.ctl_write <= 1'b0;
      link.cal_start <= 1'b0;
      link.cal_type  <= CAL_FULL;
      link.convert   <= 1'b0;
    end
    else
    begin
      link.ctl_write <= ctl_hit;
      link.cal_start <= commit_word[`CAL_START_BIT];
      link.cal_type  <= cal_type_t'(commit_word[`CALTYPE_HI:`CALTYPE_LO]);
      link.convert   <= commit_word[`CONVERT_BIT];
    end
  end

  // trigger edge; the sequencer only looks at it when not busy
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      trigger_q         <= 1'b1;
      link.trigger_fall <= 1'b0;
    end
    else
    begin
      trigger_q         <= convert_trigger_n_in;
      link.trigger_fall <= trigger_q && !convert_trigger_n_in;
    end
  end

  assign link.core_done = core_done_in;

  // conversion result, zero above the twelve result bits
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      result_reg <= `WORD_ZERO;
    else if (link.result_load)
      result_reg <= {`NIBBLE_ZERO, conv_result_in};
  end

  // busy lags the sequencer by three edges: the result takes two edges to
  // reach the lines, so with strobes tied low it leads the busy fall by one
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      busy_q1  <= 1'b0;
      busy_q2  <= 1'b0;
      busy_out <= 1'b0;
    end
    else
    begin
      busy_q1  <= link.busy_state;
      busy_q2  <= busy_q1;
      busy_out <= busy_q2;
    end
  end

  // status readback: busy, state, and whether a low byte is pending
  assign status_word = {busy_q1, low_valid, `NIBBLE_ZERO, 3'h0, link.state};

  // read source chosen by the control register
  always_comb
  begin
    unique case (control_reg[`RDSEL_HI:`RDSEL_LO])
      `RDSEL_RESULT:  read_word = result_reg;
      `RDSEL_STATUS:  read_word = status_word;
      `RDSEL_TEST:    read_word = test_reg;
      `RDSEL_CONTROL: read_word = control_reg;
    endcase
  end

  // lines follow the selected part every cycle, independent of busy, so a
  // tied-low host sees each new result without any extra strobe
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      data_out <= `LINES_ZERO;
    else
      data_out <= read_part(read_word, byte_select_in);
  end

  // the enable releases one cycle after the strobe or select rises
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      data_oe_out <= 1'b0;
    else
      data_oe_out <= rd_window;
  end

  cal_sequencer cal_sequencer_i (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .link           (link.seq),
    .conv_start_out (conv_start_out),
    .cal_start_out  (cal_start_out),
    .cal_phase_out  (cal_phase_out)
  );

endmodule

/* tb/adc_port_assertions.sv */
`timescale 1ns/1ps
module adc_port_checker
  import adc_port_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // host strobes
  input  wire logic        chip_select_n_in,
  input  wire logic        read_strobe_n_in,
  // watched outputs and core handshake
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe_out,
  input  wire logic        busy_out,
  input  wire logic        core_done_in,
  input  wire logic        conv_start_out,
  input  wire logic        cal_start_out,
  input  wire cal_phase_t  cal_phase_out
);
  // one clock domain, so clocking and reset are set once
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // read window opens the drivers one edge later
  chk_oe_follows_read: assert property ((!chip_select_n_in && !read_strobe_n_in) |=> data_oe_out)
    else $error("data lines not driven during read window");
  chk_oe_released: assert property ((chip_select_n_in || read_strobe_n_in) |=> !data_oe_out)
    else $error("data lines still driven after read window");
  // starts of work must show on busy within the lag of the sequencer
  chk_conv_busy: assert property (conv_start_out |-> ##[1:3] busy_out)
    else $error("conversion start without busy");
  chk_cal_busy: assert property (cal_start_out |-> ##[1:3] busy_out)
    else $error("calibration start without busy");
  chk_cal_phase: assert property (cal_start_out |-> cal_phase_out != PHASE_NONE)
    else $error("calibration start with no phase");
  chk_start_pulse: assert property ((conv_start_out || cal_start_out)
    |=> !conv_start_out && !cal_start_out)
    else $error("start pulse longer than one cycle");
  // busy may only drop because the core finished a phase
  chk_busy_end: assert property ($fell(busy_out) |-> $past(core_done_in, 1) || $past(core_done_in, 2)
    || $past(core_done_in, 3) || $past(core_done_in, 4))
    else $error("busy fell without core completion");
  // data must already be settled when busy falls, so the fall can latch it
  chk_data_before_busy: assert property (($fell(busy_out) && data_oe_out && $past(data_oe_out))
    |-> $stable(data_out))
    else $error("data changed on busy fall");
endmodule

bind adc_parallel_port adc_port_checker adc_port_checker_i (
  .sys_clk_in       (sys_clk_in),
  .rst_n_in         (rst_n_in),
  .chip_select_n_in (chip_select_n_in),
  .read_strobe_n_in (read_strobe_n_in),
  .data_out         (data_out),
  .data_oe_out      (data_oe_out),
  .busy_out         (busy_out),
  .core_done_in     (core_done_in),
  .conv_start_out   (conv_start_out),
  .cal_start_out    (cal_start_out),
  .cal_phase_out    (cal_phase_out)
);

/* tb/core_model.sv */
`timescale 1ns/1ps
module core_model
#(
  parameter int          DELAY  = 20,
  parameter logic [11:0] RESULT = 12'habc
)
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // start requests from the port
  input  wire logic        start_in,
  // completion and result
  output logic             core_done_out,
  output logic [11:0]      conv_result_out
);
  int count;

  // result bus is static; the port only samples it on completion
  assign conv_result_out = RESULT;

  // each started phase finishes DELAY cycles later with a one-cycle pulse
  always @(posedge sys_clk_in)
  begin
    core_done_out <= 1'b0;
    if (!rst_n_in)
      count <= 0;
    else if (start_in)
      count <= DELAY;
    else if (count == 1)
    begin
      core_done_out <= 1'b1;
      count         <= 0;
    end
    else if (count > 1)
      count <= count - 1;
  end
endmodule

/* tb/adc_parallel_port_syscal_tb.sv */
`timescale 1ns/1ps
module adc_parallel_port_syscal_tb
  import adc_port_pkg::*;
;
  logic        clk, rst_n, cs_n, rd_n, wr_n, byte_sel, trig_n;
  logic [11:0] din, dout, result;
  logic        oe, busy, done, conv_start, cal_start;
  cal_phase_t  phase;
  logic [3:0]  phase_seen;
  int          conv_count, fail_count, tests_run;

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  adc_parallel_port adc_parallel_port_i (
    .sys_clk_in(clk), .rst_n_in(rst_n), .chip_select_n_in(cs_n), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .byte_select_in(byte_sel), .convert_trigger_n_in(trig_n),
    .data_in(din), .data_out(dout), .data_oe_out(oe), .busy_out(busy), .core_done_in(done),
    .conv_result_in(result), .conv_start_out(conv_start), .cal_start_out(cal_start),
    .cal_phase_out(phase));

  core_model core_model_i (
    .sys_clk_in(clk), .rst_n_in(rst_n), .start_in(conv_start | cal_start),
    .core_done_out(done), .conv_result_out(result));

  // record what the sequencer started, independent of the scenario tasks
  always @(posedge clk)
  begin
    if (conv_start === 1'b1)
      conv_count <= conv_count + 1;
    if (cal_start === 1'b1)
      phase_seen[phase] <= 1'b1;
  end

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // the upper lines carry junk on purpose; only the low eight may count
  task automatic wr_byte(input logic sel, input logic [7:0] val);
    @(negedge clk);
    {cs_n, wr_n, byte_sel, din} = {2'b00, sel, 4'hf, val};
    @(negedge clk);
    {cs_n, wr_n, din} = {2'b11, ~din};
    repeat (3) @(negedge clk);
  endtask

  task automatic wr_word(input logic [15:0] w);
    wr_byte(1'b0, w[7:0]);
    wr_byte(1'b1, w[15:8]);
  endtask

  task automatic rd_part(input logic sel, input logic [11:0] exp, input string name);
    @(negedge clk);
    {cs_n, rd_n, byte_sel} = {2'b00, sel};
    repeat (2) @(negedge clk);
    check(name, dout, exp);
    check("oe", {11'h0, oe}, 12'h1);
    {cs_n, rd_n} = 2'b11;
    repeat (2) @(negedge clk);
    check("oe", {11'h0, oe}, 12'h0);
  endtask

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 2000 && busy !== lvl; i++)
      @(negedge clk);
    if (busy !== lvl)
    begin
      fail_count++;
      $display("mismatch busy_out expected %b seen %b", lvl, busy);
      finish_test();
    end
  endtask

  task automatic pulse_trig();
    @(negedge clk);
    trig_n = 1'b0;
    @(negedge clk);
    trig_n = 1'b1;
  endtask

  // strobes tied low through a conversion, a stray trigger while busy
  task automatic test_tied_read();
    conv_count = 0;
    @(negedge clk);
    {cs_n, rd_n, byte_sel} = 3'b000;
    pulse_trig();
    wait_busy(1'b1);
    pulse_trig();
    wait_busy(1'b0);
    check("tied low", dout, 12'habc);
    check("tied oe", {11'h0, oe}, 12'h1);
    byte_sel = 1'b1;
    repeat (2) @(negedge clk);
    check("tied high", dout, 12'h00a);
    check("starts", 12'(conv_count), 12'h1);
    {cs_n, rd_n} = 2'b11;
    rd_part(1'b1, 12'h00a, "high first");
    rd_part(1'b0, 12'habc, "low second");
    $display("test tied_read done");
  endtask

  // byte pairing, held low byte, and test register recovery
  task automatic test_registers();
    wr_word(16'h40a5);
    wr_word(16'ha000);
    rd_part(1'b0, 12'h0a5, "test low");
    rd_part(1'b1, 12'h040, "test high");
    wr_byte(1'b0, 8'h77);
    rd_part(1'b0, 12'h0a5, "held low");
    wr_byte(1'b1, 8'h40);
    rd_part(1'b0, 12'h077, "committed");
    wr_word(16'h4002);
    rd_part(1'b0, 12'h000, "recovered");
    wr_word(16'hb000);
    rd_part(1'b1, 12'h0b0, "control high");
    wr_word(16'h9000);
    rd_part(1'b0, 12'h001, "status idle");
    conv_count = 0;
    wr_word(16'h8004);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check("write starts", 12'(conv_count), 12'h1);
    rd_part(1'b0, 12'habc, "write result");
    $display("test registers done");
  endtask

  // every calibration type; separate offset then gain twice, combined three
  // times; no analog pins here, so the host levels are not modelled at the writes
  task automatic test_calibration();
    logic [3:0] first_mask [4] = '{4'h3, 4'h2, 4'h4, 4'h2};
    cal_type_t  order [8] = '{CAL_FULL, CAL_GAIN_OFF, CAL_GAIN_OFF, CAL_GAIN_OFF,
                              CAL_OFFSET, CAL_GAIN, CAL_OFFSET, CAL_GAIN};
    logic [1:0] t;
    for (int i = 0; i < 8; i++)
    begin
      t = order[i];
      phase_seen = 4'h0;
      conv_count = 0;
      wr_word({2'h2, 8'h00, t, 4'h8});
      wait_busy(1'b1);
      wait_busy(1'b0);
      check("first phases", {8'h0, phase_seen}, {8'h0, first_mask[t]});
      if (t < 2)
      begin
        phase_seen = 4'h0;
        if (t == 0)
          wr_word(16'h8004);
        else
          pulse_trig();
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("offset phase", {8'h0, phase_seen}, 12'h004);
      end
      check("no conversion", 12'(conv_count), 12'h0);
    end
    $display("test calibration done");
  endtask

  initial
  begin
    {rst_n, cs_n, rd_n, wr_n, byte_sel, trig_n, din} = {6'b011101, 12'h000};
    {fail_count, tests_run, conv_count, phase_seen} = '0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("busy after reset", {11'h0, busy}, 12'h0);
    check("oe after reset", {11'h0, oe}, 12'h0);
    test_tied_read();
    test_registers();
    test_calibration();
    finish_test();
  end
endmodule
